// ===== verification/irc_checker.sv
// Checker for irc_top: bus handshake, vectoring, return and wake pulses.
// Sees only the top ports; bound from the testbench top file.
`timescale 1ns/1ps
module irc_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Core side
  input wire logic return_from_isr,
  input wire logic vec_load,
  input wire logic [12:0] vec_pc,
  input wire logic stack_push,
  input wire logic ctx_restore,
  input wire logic wake,
  input wire logic [1:0] q_phase
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Entry pushes and vectors together; enable is off afterwards
  sequence s_enter;
    vec_load && stack_push;
  endsequence
  sequence s_quiet;
    !vec_load [*8];
  endsequence
  a_vec_fixed: assert property (vec_load |-> vec_pc == 13'h0004)
    else $error("vector address wrong");
  a_push_vec: assert property (vec_load |-> s_enter)
    else $error("no push with vector load");
  a_isr_quiet: assert property (s_enter |=> s_quiet)
    else $error("redirect while enable is off");
  a_ret_restore: assert property
    (return_from_isr |-> ##[0:2] ctx_restore)
    else $error("no context restore on return");
  a_reset_idle: assert property ($rose(rst_n) |-> s_quiet)
    else $error("redirect right after reset");
  a_q_step: assert property
    ($past(rst_n) |-> q_phase == $past(q_phase) + 2'h1)
    else $error("phase counter skipped");
  a_wait_answer: assert property
    ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
    else $error("bus answer late");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wake_pulse: assert property (wake |=> !wake)
    else $error("wake not a pulse");
endmodule : irc_checker

// ===== verification/irc_core_model.sv
// Core model: program counter, one-deep stack, return on request.
// Assumes the bench pulses ret_req for one clock after an edge.
`timescale 1ns/1ps
module irc_core_model (
  // Clock and bench command
  input wire logic clk_sys,
  input wire logic ret_req,
  // Controller outputs
  input wire logic vec_load,
  input wire logic [12:0] vec_pc,
  input wire logic stack_push,
  input wire logic [12:0] push_addr,
  // Core outputs
  output logic [12:0] core_pc,
  output logic [12:0] stack_top,
  output logic return_from_isr
);
  initial
  begin
    core_pc = 13'h0000;
    stack_top = 13'h0000;
    return_from_isr = 1'b0;
  end
  // Only one level kept: nested entry is not expected here
  always @(posedge clk_sys)
  begin
    return_from_isr <= ret_req;
    if (stack_push)
      stack_top <= push_addr;
    if (vec_load)
      core_pc <= vec_pc;
    else if (return_from_isr)
      core_pc <= stack_top;
    else
      core_pc <= core_pc + 13'h0001;
  end
endmodule : irc_core_model

// ===== verification/irc_top_test.sv
// Testbench for irc_top: register access over the bus, event sources.
// Assumes the core model beside it and the checker bound below.
`timescale 1ns/1ps
module irc_top_test;
  logic clk_sys, rst_n, avs_read, avs_write, ext_irq_pin, timer0_evt;
  logic ret_req, avs_waitrequest, vec_load, stack_push, ctx_restore, wake;
  logic return_from_isr;
  logic [3:0] avs_address, pin_change_in;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] periph_evt;
  logic [12:0] core_pc, stack_top, vec_pc, push_addr;
  logic [1:0] q_phase;
  int err_count, comparisons, n;
  // Byte enables and pin-change enables are held fixed
  irc_top #(.NPC(4)) dut (.clk_sys, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .ext_irq_pin, .pin_change_in, .pin_change_en(4'h1),
    .timer0_evt, .periph_evt, .core_pc, .return_from_isr, .stack_top,
    .vec_load, .vec_pc, .stack_push, .push_addr, .ctx_restore, .wake,
    .q_phase);
  irc_core_model core (.clk_sys, .ret_req, .vec_load, .vec_pc, .stack_push,
    .push_addr, .core_pc, .stack_top, .return_from_isr);
  task finish_test;
    $display("Counts: %0d mismatches, %0d checks", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task fail(input string m);
    err_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail
  // One bus access, held until waitrequest is sampled low
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do
    begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      fail("bus timeout");
      finish_test;
    end
    @(posedge clk_sys);
  endtask : acc
  task wr(input logic [3:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr
  task rdc(input logic [3:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    comparisons++;
    if (rd !== e)
      fail("read value mismatch");
  endtask : rdc
  // Looks for vec_load (w=0) or wake (w=1) within lim clocks
  // On a vector, the pushed address must be the core's counter of the
  // cycle before the load, which is the last one sampled without a hit
  task wait_ev(input logic w, input logic exp, input int lim);
    logic hit;
    logic [12:0] pc_seen;
    hit = 1'b0;
    n = 0;
    pc_seen = core_pc;
    while (!hit && n < lim)
    begin
      @(posedge clk_sys);
      n++;
      hit = w ? (wake === 1'b1) : (vec_load === 1'b1);
      if (!hit)
        pc_seen = core_pc;
    end
    comparisons++;
    if (hit !== exp)
      fail("event presence wrong");
    if (exp && !hit)
      finish_test;
    if (hit && !w)
    begin
      comparisons++;
      if (push_addr !== pc_seen)
        fail("pushed return address wrong");
    end
  endtask : wait_ev
  task pulse_t;
    timer0_evt <= 1'b1;
    @(posedge clk_sys);
    timer0_evt <= 1'b0;
  endtask : pulse_t
  // Pin change, then four cycles for the slowest asynchronous path
  task pin(input logic v);
    ext_irq_pin <= v;
    repeat (16) @(posedge clk_sys);
  endtask : pin
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    {rst_n, avs_read, avs_write, ext_irq_pin, timer0_evt, ret_req} = 6'h00;
    {avs_address, pin_change_in, periph_evt} = 24'h000000;
    {avs_writedata, err_count, comparisons} = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rdc(4'h0, 32'h00);
    rdc(4'hC, 32'h01);
    rdc(4'h2, 32'h00);
    $display("reset test done");
    wr(4'h0, 32'hA0);
    pulse_t;
    wait_ev(1'b0, 1'b1, 40);
    comparisons++;
    if (n < 11 || n > 17)
      fail("latency out of range");
    rdc(4'h0, 32'h24);
    pulse_t;
    wait_ev(1'b0, 1'b0, 24);
    ret_req <= 1'b1;
    @(posedge clk_sys);
    ret_req <= 1'b0;
    wait_ev(1'b0, 1'b1, 40);
    wr(4'h0, 32'hA0);
    pulse_t;
    wr(4'h0, 32'h24);
    wait_ev(1'b0, 1'b0, 24);
    wr(4'h0, 32'hA4);
    wait_ev(1'b0, 1'b1, 40);
    $display("timer test done");
    wr(4'hC, 32'h0);
    wr(4'h0, 32'h10);
    pin(1'b1);
    rdc(4'h0, 32'h10);
    pin(1'b0);
    rdc(4'h0, 32'h12);
    wr(4'hC, 32'h1);
    wr(4'h0, 32'h10);
    pin(1'b1);
    rdc(4'h0, 32'h12);
    wr(4'hC, 32'h3);
    wr(4'h0, 32'h10);
    pin(1'b0);
    pin(1'b1);
    rdc(4'h0, 32'h10);
    pin(1'b0);
    wr(4'hC, 32'h101);
    wr(4'h0, 32'h10);
    ext_irq_pin <= 1'b1;
    wait_ev(1'b1, 1'b1, 40);
    $display("edge test done");
    wr(4'h0, 32'h80);
    wr(4'h8, 32'h1);
    periph_evt <= 16'h0001;
    @(posedge clk_sys);
    periph_evt <= 16'h0000;
    wait_ev(1'b0, 1'b0, 24);
    rdc(4'h4, 32'h1);
    wr(4'h0, 32'hC0);
    wait_ev(1'b0, 1'b1, 40);
    wr(4'h0, 32'h08);
    pin_change_in <= 4'h1;
    repeat (16) @(posedge clk_sys);
    rdc(4'h0, 32'h09);
    // A change on a disabled pin-change input must not set the flag
    wr(4'h0, 32'h08);
    pin_change_in <= 4'h3;
    repeat (4) @(posedge clk_sys);
    rdc(4'h0, 32'h08);
    $display("peripheral test done");
    // Reset in mid-run with the global enable set; pins low first so
    // that the reset edge history matches the pin levels
    wr(4'h0, 32'h80);
    ext_irq_pin <= 1'b0;
    pin_change_in <= 4'h0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rdc(4'h0, 32'h00);
    $display("second reset test done");
    finish_test;
  end
endmodule : irc_top_test
bind irc_top irc_checker chk (.clk_sys, .rst_n, .avs_read, .avs_write,
  .avs_waitrequest, .return_from_isr, .vec_load, .vec_pc, .stack_push,
  .ctx_restore, .wake, .q_phase);

// ===== verilog/irc_pkg.sv
// Package for the interrupt request controller: register offsets,
// field positions, reset values and timing counts.
// Assumes a 32-bit Avalon-MM slave with word addressing by byte offset.
package irc_pkg;
  // Register byte offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;   // irq_control_reg
  localparam logic [3:0] OFF_PFLAG = 4'h4;  // periph_flag_regs
  localparam logic [3:0] OFF_PEN = 4'h8;    // periph_enable_regs
  localparam logic [3:0] OFF_CFG = 4'hC;    // Polarity, analog select, core
  // Control register fields
  localparam int GLB_EN_BIT = 7;
  localparam int GRP_EN_BIT = 6;
  localparam int TMR_EN_BIT = 5;
  localparam int EXTE_BIT = 4;
  localparam int PCE_BIT = 3;
  localparam int T0F_BIT = 2;
  localparam int EXTF_BIT = 1;
  localparam int PCF_BIT = 0;
  // Config register fields
  localparam int POL_BIT = 0;
  localparam int ANA_BIT = 1;
  localparam int SLEEP_BIT = 8;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] PREG_RST = 16'h0000;
  // Vector address
  localparam logic [12:0] VECTOR = 13'h0004;
  // Instruction cycle is four system clocks (Q1..Q4)
  localparam int Q_PER_CYCLE = 4;
  localparam int LAT_CYCLES = 3;
  localparam int LAT_CLKS = LAT_CYCLES * Q_PER_CYCLE;
  // Vectoring sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_VEC = 2'b10
  } irc_state_e;
endpackage : irc_pkg

// ===== verilog/irc_top.sv
// Interrupt request controller: flags, enables, global enable,
// fixed-vector redirection with timed latency and wake from sleep.
// Assumes the core reports return_from_isr; instruction boundaries come from the internal Q counter on q_phase.
//
// How it works
// RULE1: Each source latches into its own flag
// RULE2: Global enable gates every unmasked request
// RULE3: Each source has its own enable bit
// RULE4: Any reset clears global enable
// RULE5: Servicing clears enable, pushes, vectors 0004h
// RULE6: Flags set regardless of enables
// RULE7: In service routine events only set flags
// RULE8: Still-set enabled flag re-interrupts later
// RULE9: Clearing global enable defers, keeps pending
// RULE10: Return pops address and sets enable
// RULE11: Async pin latency three or four cycles
// RULE12: Synchronous latency exactly three cycles
// RULE13: Edge polarity chosen by select bit
// RULE14: Valid edge sets flag; enable masks
// RULE15: Software clears edge flag before reenabling
// RULE16: Edge wakes sleep if enabled before
// RULE17: Analog pin reads zero, no interrupt
// RULE18: Edge flag sampled each Q1
// RULE19: Peripheral sources need group enable
// RULE20: Pin change flag on enabled change
// RULE21: Request is gated OR of flags
// RULE22: Pin passes two-stage synchroniser first
`timescale 1ns/1ps
module irc_top #(
  parameter int NPC = 4  // Pin-change inputs
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Event sources
  input wire logic ext_irq_pin,
  input wire logic [NPC-1:0] pin_change_in,
  input wire logic [NPC-1:0] pin_change_en,
  input wire logic timer0_evt,
  input wire logic [15:0] periph_evt,
  // Core side
  input wire logic [12:0] core_pc,
  input wire logic return_from_isr,
  input wire logic [12:0] stack_top,
  output logic vec_load,
  output logic [12:0] vec_pc,
  output logic stack_push,
  output logic [12:0] push_addr,
  output logic ctx_restore,
  output logic wake,
  output logic [1:0] q_phase
);
  // Registers
  logic [7:0] ctrl_r, ctrl_nxt;      // irq_control_reg
  logic [15:0] pflag_r, pflag_nxt;   // periph_flag_regs
  logic [15:0] pen_r, pen_nxt;       // periph_enable_regs
  logic pol_r, pol_nxt;              // edge_polarity_select
  logic ana_r, ana_nxt;              // Pin as analog input
  logic sleep_r, sleep_nxt;          // Core asleep
  logic ext_en_sleep_r, ext_en_sleep_nxt; // Enable at sleep entry
  // Synchroniser and edge history
  logic sync1_r, sync2_r, prev_r;
  logic [NPC-1:0] pc_prev_r;
  // Sequencer
  irc_pkg::irc_state_e st_r, st_nxt;
  logic [3:0] lat_r, lat_nxt;
  logic [1:0] q_r, q_nxt;
  logic pending_r, pending_nxt;      // External edge seen since last Q1
  logic [31:0] rd_nxt;
  logic ack_r, ack_nxt;
  logic vec_nxt, push_nxt, rest_nxt, wake_nxt;
  logic [12:0] pa_nxt;

  // Byte-enabled merge of an 8-bit field
  function automatic logic [7:0] merge8(input logic [7:0] old,
    input logic [7:0] d, input logic be);
    merge8 = be ? d : old;
  endfunction : merge8

  // Pin value as seen by digital logic: analog reads zero
  logic pin_dig;
  assign pin_dig = ana_r ? 1'b0 : sync2_r; // RULE17

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
      pc_prev_r <= '0;
    end
    else
    begin
      sync1_r <= ext_irq_pin; // RULE22
      sync2_r <= sync1_r; // RULE22
      prev_r <= pin_dig;
      pc_prev_r <= pin_change_in;
    end
  end

  // Edge and change detection
  logic edge_hit, pc_hit, req, bus_wr, bus_rd;
  assign edge_hit = pol_r ? (pin_dig & ~prev_r) // RULE13
    : (~pin_dig & prev_r);
  assign pc_hit = |((pin_change_in ^ pc_prev_r) & pin_change_en); // RULE20
  assign bus_wr = avs_write & ~ack_r;
  assign bus_rd = avs_read & ~ack_r;

  // Gated request to the core
  assign req = ctrl_r[irc_pkg::GLB_EN_BIT] & ( // RULE2 RULE21
    (ctrl_r[irc_pkg::TMR_EN_BIT] & ctrl_r[irc_pkg::T0F_BIT]) | // RULE3
    (ctrl_r[irc_pkg::EXTE_BIT] & ctrl_r[irc_pkg::EXTF_BIT]) | // RULE14
    (ctrl_r[irc_pkg::PCE_BIT] & ctrl_r[irc_pkg::PCF_BIT]) |
    (ctrl_r[irc_pkg::GRP_EN_BIT] & |(pflag_r & pen_r))); // RULE19

  // Next-state: registers, flags, sequencer and bus answer
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    pflag_nxt = pflag_r;
    pen_nxt = pen_r;
    pol_nxt = pol_r;
    ana_nxt = ana_r;
    sleep_nxt = sleep_r;
    ext_en_sleep_nxt = ext_en_sleep_r;
    st_nxt = st_r;
    lat_nxt = lat_r;
    q_nxt = q_r + 2'h1;
    pending_nxt = pending_r | edge_hit;
    rd_nxt = 32'h0;
    ack_nxt = 1'b0;
    vec_nxt = 1'b0;
    push_nxt = 1'b0;
    rest_nxt = 1'b0;
    wake_nxt = 1'b0;
    pa_nxt = push_addr;
    // Software writes first so that hardware sets win
    if (bus_wr)
    begin
      ack_nxt = 1'b1;
      if (avs_address == irc_pkg::OFF_CTRL)
        ctrl_nxt = merge8(ctrl_r, avs_writedata[7:0], avs_byteenable[0]);
      else if (avs_address == irc_pkg::OFF_PFLAG)
      begin
        pflag_nxt[7:0] = merge8(pflag_r[7:0], avs_writedata[7:0],
          avs_byteenable[0]);
        pflag_nxt[15:8] = merge8(pflag_r[15:8], avs_writedata[15:8],
          avs_byteenable[1]);
      end
      else if (avs_address == irc_pkg::OFF_PEN)
      begin
        pen_nxt[7:0] = merge8(pen_r[7:0], avs_writedata[7:0],
          avs_byteenable[0]);
        pen_nxt[15:8] = merge8(pen_r[15:8], avs_writedata[15:8],
          avs_byteenable[1]);
      end
      else if (avs_address == irc_pkg::OFF_CFG)
      begin
        if (avs_byteenable[0])
        begin
          pol_nxt = avs_writedata[irc_pkg::POL_BIT];
          ana_nxt = avs_writedata[irc_pkg::ANA_BIT];
        end
        if (avs_byteenable[1])
        begin
          sleep_nxt = avs_writedata[irc_pkg::SLEEP_BIT];
          // Remember enable state at sleep entry
          ext_en_sleep_nxt = ctrl_r[irc_pkg::EXTE_BIT]; // RULE16
        end
      end
    end
    else if (bus_rd)
    begin
      ack_nxt = 1'b1;
      if (avs_address == irc_pkg::OFF_CTRL)
        rd_nxt = {24'h0, ctrl_r};
      else if (avs_address == irc_pkg::OFF_PFLAG)
        rd_nxt = {16'h0, pflag_r};
      else if (avs_address == irc_pkg::OFF_PEN)
        rd_nxt = {16'h0, pen_r};
      else if (avs_address == irc_pkg::OFF_CFG)
        rd_nxt = {23'h0, sleep_r, 6'h0, ana_r, pol_r};
      else
        rd_nxt = 32'h0; // Unmapped reads zero
    end
    // Hardware sets, independent of the interrupt enables; the pin-change flag also needs pin_change_en
    pflag_nxt = pflag_nxt | periph_evt; // RULE1 RULE6
    if (timer0_evt)
      ctrl_nxt[irc_pkg::T0F_BIT] = 1'b1; // RULE6
    if (pc_hit)
      ctrl_nxt[irc_pkg::PCF_BIT] = 1'b1; // RULE20
    // External edge enters the flag at Q1 only
    if (q_r == 2'h0)
    begin
      if (pending_r | edge_hit)
        ctrl_nxt[irc_pkg::EXTF_BIT] = 1'b1; // RULE18 RULE14
      pending_nxt = 1'b0;
    end
    // Wake: enabled edge flag while asleep
    if (sleep_r && ctrl_r[irc_pkg::EXTF_BIT] && ext_en_sleep_r &&
        ctrl_r[irc_pkg::EXTE_BIT])
    begin
      sleep_nxt = 1'b0; // RULE16
      wake_nxt = 1'b1;
    end
    // Return from service routine
    if (return_from_isr)
    begin
      ctrl_nxt[irc_pkg::GLB_EN_BIT] = 1'b1; // RULE10
      pa_nxt = stack_top;
      rest_nxt = 1'b1;
    end
    // Vectoring sequencer
    case (st_r)
      irc_pkg::ST_IDLE:
        // Start only at Q1, so latency is whole instruction cycles
        if (req && q_r == 2'h0 && !sleep_r)
        begin
          st_nxt = irc_pkg::ST_WAIT; // RULE12 RULE11
          lat_nxt = 4'(irc_pkg::LAT_CLKS - 1);
        end
      irc_pkg::ST_WAIT:
        if (!ctrl_r[irc_pkg::GLB_EN_BIT])
          st_nxt = irc_pkg::ST_IDLE; // RULE9 RULE7 flag kept
        else if (lat_r == 4'h1)
          st_nxt = irc_pkg::ST_VEC;
        else
          lat_nxt = lat_r - 4'h1;
      irc_pkg::ST_VEC:
      begin
        ctrl_nxt[irc_pkg::GLB_EN_BIT] = 1'b0; // RULE5
        vec_nxt = 1'b1; // RULE5
        push_nxt = 1'b1;
        pa_nxt = core_pc;
        st_nxt = irc_pkg::ST_IDLE; // RULE8 re-arm while flag set
      end
      default:
        st_nxt = irc_pkg::ST_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctrl_r <= irc_pkg::CTRL_RST; // RULE4
      pflag_r <= irc_pkg::PREG_RST;
      pen_r <= irc_pkg::PREG_RST;
      pol_r <= 1'b1;
      ana_r <= 1'b0;
      sleep_r <= 1'b0;
      ext_en_sleep_r <= 1'b0;
      st_r <= irc_pkg::ST_IDLE;
      lat_r <= 4'h0;
      q_r <= 2'h0;
      pending_r <= 1'b0;
      avs_readdata <= 32'h0;
      ack_r <= 1'b0;
      vec_load <= 1'b0;
      stack_push <= 1'b0;
      push_addr <= 13'h0;
      ctx_restore <= 1'b0;
      wake <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      pflag_r <= pflag_nxt;
      pen_r <= pen_nxt;
      pol_r <= pol_nxt;
      ana_r <= ana_nxt;
      sleep_r <= sleep_nxt;
      ext_en_sleep_r <= ext_en_sleep_nxt;
      st_r <= st_nxt;
      lat_r <= lat_nxt;
      q_r <= q_nxt;
      pending_r <= pending_nxt;
      avs_readdata <= rd_nxt;
      ack_r <= ack_nxt;
      vec_load <= vec_nxt;
      stack_push <= push_nxt;
      push_addr <= pa_nxt;
      ctx_restore <= rest_nxt;
      wake <= wake_nxt;
    end
  end

  // Waitrequest is the inverse of the one-cycle ack, held high idle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~ack_nxt;
  end

  // Vector and phase outputs
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      vec_pc <= 13'h0;
      q_phase <= 2'h0;
    end
    else
    begin
      vec_pc <= irc_pkg::VECTOR; // RULE5
      q_phase <= q_nxt;
    end
  end
endmodule : irc_top
